// >>> logic/ptme_timer.sv
/*
 periodic timer mode engine: up-counter with period and secondary
 comparators, compare output, timer, pwm, single pulse and capture modes,
 with a classic wishbone slave for its registers.
 assumes a single 125 MHz clock and asynchronous external pins.
*/
`default_nettype none
module ptme_timer
#(
	parameter int CNT_WIDTH = 16
)
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// external pins
	input wire logic external_clock_pin,
	input wire logic timer_pin_zero,
	input wire logic timer_pin_one,
	// timer outputs
	output logic timer_out,
	output logic timer_out_en
);
	import ptme_pkg::*;

	if (CNT_WIDTH < 2 || CNT_WIDTH > 16)
	begin : g_width_check
		$error("CNT_WIDTH must be 2..16");
	end

	logic [11:0] ctrl_reg;
	logic [CNT_WIDTH-1:0] sec_reg;
	logic [CNT_WIDTH-1:0] per_reg;
	logic [CNT_WIDTH-1:0] cnt_reg;
	logic secf_reg;
	logic perf_reg;
	logic out_reg;
	logic run_d_reg;
	logic ack_reg;
	logic [31:0] rdat_reg;
	logic [1:0] div_reg;

	logic ext_lvl, ext_rise, ext_fall;
	logic p0_lvl, p0_rise, p0_fall;
	logic p1_lvl, p1_rise, p1_fall;

	ptme_pin_sync u_ext
	(
		.sys_clk(sys_clk),
		.reset(reset),
		.pin_in(external_clock_pin),
		.level(ext_lvl),
		.rise(ext_rise),
		.fall(ext_fall)
	);
	ptme_pin_sync u_p0
	(
		.sys_clk(sys_clk),
		.reset(reset),
		.pin_in(timer_pin_zero),
		.level(p0_lvl),
		.rise(p0_rise),
		.fall(p0_fall)
	);
	ptme_pin_sync u_p1
	(
		.sys_clk(sys_clk),
		.reset(reset),
		.pin_in(timer_pin_one),
		.level(p1_lvl),
		.rise(p1_rise),
		.fall(p1_fall)
	);

	logic run, pause, clr_sel, cap_src, inv, init_lvl;
	logic [1:0] pinf, mode, cksel;
	assign run = ctrl_reg[PTME_RUN_POS];
	assign pause = ctrl_reg[PTME_PAUSE_POS];
	assign clr_sel = ctrl_reg[PTME_CLR_POS];
	assign cap_src = ctrl_reg[PTME_CAPSRC_POS];
	assign inv = ctrl_reg[PTME_INV_POS];
	assign init_lvl = ctrl_reg[PTME_INIT_POS];
	assign pinf = ctrl_reg[PTME_PINF_POS +: 2];
	assign mode = ctrl_reg[PTME_MODE_POS +: 2];
	assign cksel = ctrl_reg[PTME_CKSEL_POS +: 2];

	logic is_pwm, is_single, run_rise, ext_edge;
	assign is_pwm = (mode == PTME_MODE_PWM) && (pinf != PTME_PF_11);
	assign is_single = (mode == PTME_MODE_PWM) && (pinf == PTME_PF_11);
	assign run_rise = run && !run_d_reg;
	assign ext_edge = (cksel == PTME_CK_EFALL) ? ext_fall : ext_rise;

	// prescaled tick
	always_ff @(posedge sys_clk)
	begin
		if (reset)
			div_reg <= 2'h0;
		else
			div_reg <= div_reg + 2'h1;
	end

	logic tick;
	always_comb
	begin
		case (cksel)
			PTME_CK_SYS: tick = 1'b1;
			PTME_CK_DIV: tick = (div_reg == 2'(PTME_DIV_COUNT - 1));
			default: tick = ext_edge;
		endcase
	end

	logic advance;
	assign advance = run && !run_rise && !pause && tick;

	logic sec_hit, per_hit, ovf_hit;
	assign sec_hit = advance && (cnt_reg == sec_reg);
	assign per_hit = advance && (cnt_reg == per_reg) && (per_reg != '0);
	assign ovf_hit = advance && (cnt_reg == '1);

	// a pwm period of n counts wraps one count before the period value
	logic pwm_wrap;
	assign pwm_wrap = advance && (per_reg != '0)
		&& (cnt_reg == per_reg - 1'b1);

	// wishbone access
	// writes land at the edge where the master samples ack
	logic wb_req, wb_wr, wr_ctrl, wr_sec, wr_per, wr_stat;
	assign wb_req = wb_cyc_i && wb_stb_i && !ack_reg;
	assign wb_wr = wb_cyc_i && wb_stb_i && wb_we_i && ack_reg;
	assign wr_ctrl = wb_wr && (wb_adr_i == PTME_CTRL_OFS);
	assign wr_sec = wb_wr && (wb_adr_i == PTME_SEC_OFS);
	assign wr_per = wb_wr && (wb_adr_i == PTME_PER_OFS);
	assign wr_stat = wb_wr && (wb_adr_i == PTME_STAT_OFS);

	logic [31:0] wmask;
	always_comb
	begin
		wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
			{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
	end

	// counter: zeroed on run rise, clears per mode
	always_ff @(posedge sys_clk)
	begin
		if (reset)
			cnt_reg <= '0;
		else if (run_rise)
			cnt_reg <= '0;
		else if (advance)
		begin
			case (mode)
				PTME_MODE_CMP, PTME_MODE_TMR:
				begin
					if (clr_sel && sec_hit)
						cnt_reg <= '0;
					else if (!clr_sel && per_hit)
						cnt_reg <= '0;
					else
						cnt_reg <= cnt_reg + 1'b1;
				end
				PTME_MODE_PWM:
				begin
					// period zero wraps naturally at full range
					if (is_pwm && pwm_wrap)
						cnt_reg <= '0;
					else
						cnt_reg <= cnt_reg + 1'b1;
				end
				PTME_MODE_CAP:
				begin
					if (per_hit)
						cnt_reg <= '0;
					else
						cnt_reg <= cnt_reg + 1'b1;
				end
				default: cnt_reg <= cnt_reg + 1'b1;
			endcase
		end
	end

	// capture input selection and edge
	logic cap_rise, cap_fall, cap_hit;
	always_comb
	begin
		if (cap_src)
		begin
			cap_rise = ext_rise;
			cap_fall = ext_fall;
		end
		else
		begin
			cap_rise = p0_rise || p1_rise;
			cap_fall = p0_fall || p1_fall;
		end
		case (pinf)
			PTME_PF_00: cap_hit = cap_rise;
			PTME_PF_01: cap_hit = cap_fall;
			PTME_PF_10: cap_hit = cap_rise || cap_fall;
			default: cap_hit = 1'b0;
		endcase
		cap_hit = cap_hit && run && (mode == PTME_MODE_CAP);
	end

	// secondary compare value, loaded by software or by capture
	always_ff @(posedge sys_clk)
	begin
		if (reset)
			sec_reg <= '0;
		else if (cap_hit)
			sec_reg <= cnt_reg;
		else if (wr_sec)
			sec_reg <= (sec_reg & ~wmask[CNT_WIDTH-1:0])
				| (wb_dat_i[CNT_WIDTH-1:0] & wmask[CNT_WIDTH-1:0]);
	end

	always_ff @(posedge sys_clk)
	begin
		if (reset)
			per_reg <= '0;
		else if (wr_per)
			per_reg <= (per_reg & ~wmask[CNT_WIDTH-1:0])
				| (wb_dat_i[CNT_WIDTH-1:0] & wmask[CNT_WIDTH-1:0]);
	end

	// flag events per mode
	logic sec_ev, per_ev;
	always_comb
	begin
		case (mode)
			PTME_MODE_CMP, PTME_MODE_TMR:
			begin
				sec_ev = sec_hit;
				per_ev = !clr_sel && (per_hit || (per_reg == '0 && ovf_hit));
			end
			PTME_MODE_PWM:
			begin
				sec_ev = sec_hit;
				per_ev = is_pwm && (pwm_wrap || (per_reg == '0 && ovf_hit));
			end
			PTME_MODE_CAP:
			begin
				sec_ev = cap_hit;
				per_ev = per_hit || (per_reg == '0 && ovf_hit);
			end
			default:
			begin
				sec_ev = 1'b0;
				per_ev = 1'b0;
			end
		endcase
	end

	// write one to clear; a new event wins over the clear
	always_ff @(posedge sys_clk)
	begin
		if (reset)
			secf_reg <= 1'b0;
		else if (sec_ev)
			secf_reg <= 1'b1;
		else if (wr_stat && wb_sel_i[0] && wb_dat_i[PTME_SECF_POS])
			secf_reg <= 1'b0;
	end

	always_ff @(posedge sys_clk)
	begin
		if (reset)
			perf_reg <= 1'b0;
		else if (per_ev)
			perf_reg <= 1'b1;
		else if (wr_stat && wb_sel_i[0] && wb_dat_i[PTME_PERF_POS])
			perf_reg <= 1'b0;
	end

	// control: software writes, single pulse sets and clears run itself
	always_ff @(posedge sys_clk)
	begin
		if (reset)
			ctrl_reg <= PTME_CTRL_RST;
		else
		begin
			if (wr_ctrl)
				ctrl_reg <= (ctrl_reg & ~wmask[11:0])
					| (wb_dat_i[11:0] & wmask[11:0]);
			if (is_single && run && sec_hit)
				ctrl_reg[PTME_RUN_POS] <= 1'b0;
			else if (is_single && !run && ext_edge)
				ctrl_reg[PTME_RUN_POS] <= 1'b1;
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (reset)
			run_d_reg <= 1'b0;
		else
			run_d_reg <= run;
	end

	// compare mode pin state
	always_ff @(posedge sys_clk)
	begin
		if (reset)
			out_reg <= 1'b0;
		else if (run_rise)
			out_reg <= init_lvl;
		else if (mode == PTME_MODE_CMP && sec_hit)
		begin
			case (pinf)
				PTME_PF_01: out_reg <= 1'b0;
				PTME_PF_10: out_reg <= 1'b1;
				PTME_PF_11: out_reg <= !out_reg;
				default: out_reg <= out_reg;
			endcase
		end
	end

	// pwm active while counter below duty; duty at or over period stays on
	logic pwm_act, pulse_act, out_next;
	assign pwm_act = run && ((cnt_reg < sec_reg)
		|| (per_reg != '0 && sec_reg >= per_reg));
	assign pulse_act = run;
	always_comb
	begin
		case (mode)
			PTME_MODE_CMP: out_next = out_reg ^ inv;
			PTME_MODE_PWM:
			begin
				case (pinf)
					PTME_PF_00: out_next = !init_lvl;
					PTME_PF_01: out_next = init_lvl;
					PTME_PF_10: out_next = pwm_act ? init_lvl : !init_lvl;
					default: out_next = pulse_act ? init_lvl : !init_lvl;
				endcase
				out_next = out_next ^ inv;
			end
			default: out_next = 1'b0;
		endcase
	end

	logic tout_reg, toen_reg;
	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			tout_reg <= 1'b0;
			toen_reg <= 1'b0;
		end
		else
		begin
			tout_reg <= out_next;
			// pin released in timer and capture modes
			toen_reg <= (mode == PTME_MODE_CMP) || (mode == PTME_MODE_PWM);
		end
	end
	assign timer_out = tout_reg;
	assign timer_out_en = toen_reg;

	// read data and ack: registered, one wait state, ack drops next cycle
	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			ack_reg <= 1'b0;
			rdat_reg <= 32'h0000_0000;
		end
		else
		begin
			ack_reg <= wb_req;
			rdat_reg <= 32'h0000_0000;
			if (wb_req && !wb_we_i)
			begin
				case (wb_adr_i)
					PTME_CTRL_OFS: rdat_reg[11:0] <= ctrl_reg;
					PTME_SEC_OFS: rdat_reg[CNT_WIDTH-1:0] <= sec_reg;
					PTME_PER_OFS: rdat_reg[CNT_WIDTH-1:0] <= per_reg;
					PTME_STAT_OFS:
					begin
						rdat_reg[PTME_SECF_POS] <= secf_reg;
						rdat_reg[PTME_PERF_POS] <= perf_reg;
						rdat_reg[PTME_OUT_POS] <= tout_reg;
						rdat_reg[PTME_CNT_POS +: CNT_WIDTH] <= cnt_reg;
					end
					default: rdat_reg <= 32'h0000_0000;
				endcase
			end
		end
	end
	assign wb_ack_o = ack_reg;
	assign wb_dat_o = rdat_reg;

	logic unused;
	assign unused = ext_lvl ^ p0_lvl ^ p1_lvl;
endmodule // ptme_timer
`default_nettype wire

// >>> logic/ptme_pkg.sv
/*
 periodic timer mode engine: register offsets, field positions, reset
 values and mode encodings shared by the design files.
 assumes a 32-bit classic wishbone bus with word-aligned registers.
*/
`default_nettype none
package ptme_pkg;
	localparam logic [3:0] PTME_CTRL_OFS = 4'h0;
	localparam logic [3:0] PTME_SEC_OFS = 4'h4;
	localparam logic [3:0] PTME_PER_OFS = 4'h8;
	localparam logic [3:0] PTME_STAT_OFS = 4'hC;
	// control register field positions
	localparam int PTME_RUN_POS = 0;
	localparam int PTME_PAUSE_POS = 1;
	localparam int PTME_CLR_POS = 2;
	localparam int PTME_CAPSRC_POS = 3;
	localparam int PTME_INV_POS = 4;
	localparam int PTME_INIT_POS = 5;
	localparam int PTME_PINF_POS = 6;
	localparam int PTME_MODE_POS = 8;
	localparam int PTME_CKSEL_POS = 10;
	// status register field positions
	localparam int PTME_SECF_POS = 0;
	localparam int PTME_PERF_POS = 1;
	localparam int PTME_OUT_POS = 2;
	localparam int PTME_CNT_POS = 16;
	localparam logic [11:0] PTME_CTRL_RST = 12'h000;
	localparam logic [1:0] PTME_MODE_CMP = 2'h0;
	localparam logic [1:0] PTME_MODE_CAP = 2'h1;
	localparam logic [1:0] PTME_MODE_PWM = 2'h2;
	localparam logic [1:0] PTME_MODE_TMR = 2'h3;
	localparam logic [1:0] PTME_PF_00 = 2'h0;
	localparam logic [1:0] PTME_PF_01 = 2'h1;
	localparam logic [1:0] PTME_PF_10 = 2'h2;
	localparam logic [1:0] PTME_PF_11 = 2'h3;
	// clock select: 0 sys_clk, 1 prescaled tick, 2 ext rise, 3 ext fall
	localparam logic [1:0] PTME_CK_SYS = 2'h0;
	localparam logic [1:0] PTME_CK_DIV = 2'h1;
	localparam logic [1:0] PTME_CK_ERISE = 2'h2;
	localparam logic [1:0] PTME_CK_EFALL = 2'h3;
	localparam int PTME_DIV_COUNT = 4;
endpackage
`default_nettype wire

// >>> logic/ptme_pin_sync.sv
/*
 three-stage synchroniser with agreement filter and edge pulses.
 assumes an asynchronous pin level on input; one clock domain.
*/
`default_nettype none
module ptme_pin_sync
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// pin side
	input wire logic pin_in,
	// filtered level and edges
	output logic level,
	output logic rise,
	output logic fall
);
	logic [2:0] sync_reg;
	logic level_reg;

	always_ff @(posedge sys_clk)
	begin
		if (reset)
			sync_reg <= 3'h0;
		else
			sync_reg <= {sync_reg[1:0], pin_in};
	end

	// stage 0 feeds stage 1 only; stages 1 and 2 must agree
	always_ff @(posedge sys_clk)
	begin
		if (reset)
			level_reg <= 1'b0;
		else if (sync_reg[2] == sync_reg[1])
			level_reg <= sync_reg[2];
	end

	assign level = level_reg;
	assign rise = (sync_reg[2] == sync_reg[1]) && sync_reg[2] && !level_reg;
	assign fall = (sync_reg[2] == sync_reg[1]) && !sync_reg[2] && level_reg;
endmodule // ptme_pin_sync
`default_nettype wire

// >>> bench/ptme_timer_properties.sv
/*
 port checks for the timer, bound into ptme_timer.
 assumes one clock and full-word control writes from the bus master.
*/
`default_nettype none
module ptme_timer_checker
	import ptme_pkg::*;
#(
	parameter int CNT_WIDTH = 16
)
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// bus
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	// pin
	input wire logic timer_out,
	input wire logic timer_out_en
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [11:0] ctl_reg;
	logic [3:0] quiet_reg;
	logic seen_reg;
	logic ctl_wr;
	logic [1:0] mode;
	assign ctl_wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o
		&& wb_adr_i == PTME_CTRL_OFS && wb_sel_i[1:0] == 2'h3;
	assign mode = ctl_reg[9:8];
	// shadow of control, so pin checks know the mode
	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			ctl_reg <= 12'h000;
			seen_reg <= 1'b0;
		end
		else if (ctl_wr)
		begin
			ctl_reg <= wb_dat_i[11:0];
			seen_reg <= 1'b1;
		end
	end
	// settling time after a control write, saturating
	always_ff @(posedge sys_clk)
	begin
		if (reset || ctl_wr)
			quiet_reg <= 4'h0;
		else if (quiet_reg != 4'hF)
			quiet_reg <= quiet_reg + 4'h1;
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (reset);
	a_ack_follows:
	assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("bus request not answered next cycle");
	a_ack_pulse:
	assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	a_data_idle:
	assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
		else $error("read data outside ack");
	a_hole_reads_zero:
	assert property (wb_ack_o && !wb_we_i
		&& ($past(wb_adr_i) & 4'h3) != 4'h0 |-> wb_dat_o == 32'h0)
		else $error("unaligned read not zero");
	a_out_enable:
	assert property (seen_reg && quiet_reg >= 4'h4 |-> timer_out_en
		== (mode == PTME_MODE_CMP || mode == PTME_MODE_PWM))
		else $error("pin enable wrong for mode");
	a_run_loads_init:
	assert property (ctl_wr && wb_dat_i[0] && !ctl_reg[0]
		&& wb_dat_i[9:8] == PTME_MODE_CMP
		|=> ##[0:2] timer_out == (ctl_reg[5] ^ ctl_reg[4]))
		else $error("run rise did not load initial level");
	a_cmp_hold:
	assert property (mode == PTME_MODE_CMP && ctl_reg[7:6] == PTME_PF_00
		&& quiet_reg >= 4'h4 |-> $stable(timer_out))
		else $error("pin moved with no-change function");
	a_pwm_forced:
	assert property (mode == PTME_MODE_PWM && !ctl_reg[7] && ctl_reg[0]
		&& quiet_reg >= 4'h6 |-> timer_out
		== ((ctl_reg[6] ? ctl_reg[5] : !ctl_reg[5]) ^ ctl_reg[4]))
		else $error("forced pwm level wrong");
endmodule // ptme_timer_checker
bind ptme_timer ptme_timer_checker #(.CNT_WIDTH(CNT_WIDTH)) u_checker (
	.sys_clk(sys_clk), .reset(reset), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
	.wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
	.wb_ack_o(wb_ack_o), .timer_out(timer_out),
	.timer_out_en(timer_out_en)
);
`default_nettype wire

// >>> bench/ptme_pin_model.sv
/*
 outside circuit on the timer's input pins.
 assumes requests change at the rising edge; pins move one cycle later.
*/
`default_nettype none
module ptme_pin_model
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// bit 2 external clock, bit 1 pin one, bit 0 pin zero
	input wire logic [2:0] level_req,
	// pins
	output logic external_clock_pin,
	output logic timer_pin_one,
	output logic timer_pin_zero
);
	timeunit 1ns;
	timeprecision 1ps;
	always @(posedge sys_clk)
	begin
		if (reset)
			{external_clock_pin, timer_pin_one, timer_pin_zero} <= 3'h0;
		else
			{external_clock_pin, timer_pin_one, timer_pin_zero} <= level_req;
	end
endmodule // ptme_pin_model
`default_nettype wire

// >>> bench/test_periodic_timer_mode_engine.sv
/*
 self-checking bench for the 10-bit timer variant.
 assumes the pin model and the bound checker are compiled alongside.
*/
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
	err_count++; $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); \
	end end
module test_periodic_timer_mode_engine;
	import ptme_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	// short counter keeps the zero-period wrap at 1024 cycles
	localparam int W = 10;
	logic sys_clk = 1'b0;
	logic reset = 1'b1;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [3:0] adr = 4'h0;
	logic [31:0] dat = 32'h0;
	logic [2:0] pins_req = 3'h0;
	logic [31:0] seed = 32'h55CF;
	logic [11:0] ctl_now = 12'h000;
	logic [31:0] dout, q;
	logic ack, tout, ten, ext_pin, pin0, pin1, inv;
	int err_count = 0;
	int samples_checked = 0;
	int cycles = 0;
	int hi, win, act, p, d, k;
	always #4 sys_clk = ~sys_clk;
	ptme_timer #(.CNT_WIDTH(W)) dut (
		.sys_clk(sys_clk), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat),
		.wb_dat_o(dout), .wb_ack_o(ack), .external_clock_pin(ext_pin),
		.timer_pin_zero(pin0), .timer_pin_one(pin1), .timer_out(tout),
		.timer_out_en(ten)
	);
	ptme_pin_model u_pins (
		.sys_clk(sys_clk), .reset(reset), .level_req(pins_req),
		.external_clock_pin(ext_pin), .timer_pin_one(pin1),
		.timer_pin_zero(pin0)
	);
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic bus(input logic w, input logic [3:0] a,
		input logic [31:0] v);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= v;
		do @(posedge sys_clk); while (ack !== 1'b1);
		q = dout;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge sys_clk);
	endtask
	// stop first: mode and pin function only change while stopped
	task automatic setup(input logic [11:0] c, input logic [15:0] s,
		input logic [15:0] pv);
		bus(1'b1, PTME_CTRL_OFS, {20'h0, ctl_now & 12'hFFE});
		bus(1'b1, PTME_CTRL_OFS, {20'h0, c & 12'hFFE});
		bus(1'b1, PTME_STAT_OFS, 32'h3);
		bus(1'b1, PTME_SEC_OFS, {16'h0, s});
		bus(1'b1, PTME_PER_OFS, {16'h0, pv});
		bus(1'b1, PTME_CTRL_OFS, {20'h0, c});
		ctl_now = c;
	endtask
	task automatic count_high(input int n);
		hi = 0;
		repeat (n)
		begin
			@(posedge sys_clk);
			hi += (tout === 1'b1);
		end
	endtask
	task automatic read_chk_wait(input int n, input logic [3:0] a);
		repeat (n) @(posedge sys_clk);
		bus(1'b0, a, 32'h0);
	endtask
	// ceiling well above the longest pwm window plus setup traffic
	always @(posedge sys_clk)
	begin
		cycles++;
		if (cycles == 40000)
		begin
			err_count++;
			report_and_stop();
		end
	end
	initial
	begin
		repeat (16) @(posedge sys_clk);
		reset <= 1'b0;
		@(posedge sys_clk);
		read_chk_wait(0, PTME_CTRL_OFS);
		`CHK(q[11:0], PTME_CTRL_RST)
		read_chk_wait(0, PTME_STAT_OFS);
		`CHK(q, 32'h0)
		read_chk_wait(0, 4'h2);
		`CHK(q, 32'h0)
		setup(12'h081, 16'h3, 16'h6);
		read_chk_wait(40, PTME_STAT_OFS);
		`CHK(q[1:0], 2'h3)
		`CHK({ten, tout}, 2'h3)
		setup(12'h065, 16'h5, 16'h2);
		read_chk_wait(40, PTME_STAT_OFS);
		`CHK(q[1:0], 2'h1)
		`CHK(tout, 1'b0)
		setup(12'h3C1, 16'h3, 16'h6);
		read_chk_wait(40, PTME_STAT_OFS);
		`CHK({ten, q[1:0]}, 3'h3)
		// no-change pin function: flags still raise, pin keeps its level
		setup(12'h001, 16'h3, 16'h6);
		read_chk_wait(20, PTME_STAT_OFS);
		`CHK({tout, q[1:0]}, 3'h3)
		// prescaled tick, then pause freezes the count
		setup(12'h701, 16'h3FF, 16'h0);
		read_chk_wait(40, PTME_STAT_OFS);
		`CHK(q[25:16] >= 10'h8 && q[25:16] <= 10'hC, 1'b1)
		bus(1'b1, PTME_CTRL_OFS, 32'h703);
		ctl_now = 12'h703;
		read_chk_wait(4, PTME_STAT_OFS);
		d = q[25:16];
		read_chk_wait(20, PTME_STAT_OFS);
		`CHK(q[25:16], d[9:0])
		// random pwm: duty may reach past the period
		for (k = 0; k < 4; k++)
		begin
			p = (k == 0) ? 0 : 2 + rnd() % 30;
			d = rnd() % 40;
			inv = 1'(rnd());
			setup(12'h2A5 | {7'h0, inv, 4'h0}, d[15:0], p[15:0]);
			win = (p == 0) ? 2 << W : 2 * p;
			act = (d < win / 2) ? 2 * d : win;
			repeat (8) @(posedge sys_clk);
			count_high(win);
			`CHK(hi, inv ? win - act : act)
			read_chk_wait(0, PTME_STAT_OFS);
			`CHK(q[1], 1'b1)
		end
		setup(12'h225, 16'h3, 16'h9);
		read_chk_wait(30, PTME_STAT_OFS);
		`CHK({tout, q[1:0]}, 3'h3)
		setup(12'h265, 16'h3, 16'h9);
		read_chk_wait(30, PTME_STAT_OFS);
		`CHK({tout, q[1:0]}, 3'h7)
		// single pulse with a period value that would cut it short
		setup(12'h2E1, 16'hC, 16'h3);
		count_high(40);
		`CHK(hi >= 9 && hi <= 14, 1'b1)
		read_chk_wait(0, PTME_CTRL_OFS);
		`CHK(q[0], 1'b0)
		read_chk_wait(0, PTME_STAT_OFS);
		`CHK(q[0], 1'b1)
		// counting on outside edges, so only the pin starts the pulse
		setup(12'hAE0, 16'hC, 16'h3);
		pins_req <= 3'h4;
		read_chk_wait(10, PTME_CTRL_OFS);
		`CHK({tout, q[0]}, 2'h3)
		bus(1'b1, PTME_CTRL_OFS, 32'hAE0);
		repeat (4) @(posedge sys_clk);
		`CHK(tout, 1'b0)
		pins_req <= 3'h0;
		setup(12'h101, 16'h3FF, 16'h0);
		repeat (20) @(posedge sys_clk);
		pins_req <= 3'h1;
		read_chk_wait(10, PTME_SEC_OFS);
		`CHK(q[9:0] > 10'h10 && q[9:0] < 10'h30, 1'b1)
		read_chk_wait(0, PTME_STAT_OFS);
		`CHK(q[0], 1'b1)
		setup(12'h1C1, 16'h3FF, 16'h20);
		pins_req <= 3'h6;
		read_chk_wait(80, PTME_SEC_OFS);
		`CHK(q[9:0], 10'h3FF)
		read_chk_wait(0, PTME_STAT_OFS);
		`CHK(q[1:0], 2'h2)
		pins_req <= 3'h0;
		setup(12'h109, 16'h3FF, 16'h0);
		pins_req <= 3'h3;
		read_chk_wait(10, PTME_SEC_OFS);
		`CHK(q[9:0], 10'h3FF)
		pins_req <= 3'h7;
		read_chk_wait(10, PTME_SEC_OFS);
		`CHK(q[9:0] !== 10'h3FF, 1'b1)
		report_and_stop();
	end
endmodule // test_periodic_timer_mode_engine
`default_nettype wire
